/* rtl/cmp1_flag.sv */
/*
 * one sticky event flag: hardware sets, software writes.
 * assumes set and write arrive on the same system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp1_flag (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic set,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      flag_r
);
    import cmp1_pkg::*;

    logic flag_nxt;

    // a set in the same cycle as a clear wins, so no event is lost
    assign flag_nxt = set | (wr_en ? wr_val : flag_r);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : cmp1_flag

`default_nettype wire

/* rtl/cmp1_pkg.sv */
/*
 * constants, field layout and carrier types for the second comparator's
 * control register bank.
 * assumes an 8-bit register port and a 20 MHz system clock.
 */
package cmp1_pkg;

    // register offsets on the register port
    localparam logic [7:0] CMP1_OFS_CTRL = 8'h9A;
    localparam logic [7:0] CMP1_OFS_MODE = 8'h9C;
    localparam logic [7:0] CMP1_OFS_MUX  = 8'h9F;

    // values after reset
    localparam logic [7:0] CMP1_RST_CTRL = 8'h00;
    localparam logic [7:0] CMP1_RST_MODE = 8'h02;
    localparam logic [7:0] CMP1_RST_MUX  = 8'h00;

    // control register fields
    localparam int CMP1_CTRL_EN     = 7;
    localparam int CMP1_CTRL_RESULT = 6;
    localparam int CMP1_CTRL_RISE   = 5;
    localparam int CMP1_CTRL_FALL   = 4;
    localparam int CMP1_CTRL_HYP_LO = 2;
    localparam int CMP1_CTRL_HYN_LO = 0;

    // mode register fields
    localparam int CMP1_MODE_RIE    = 5;
    localparam int CMP1_MODE_FIE    = 4;
    localparam int CMP1_MODE_MD_LO  = 0;

    // input select register fields
    localparam int CMP1_MUX_N_LO    = 4;
    localparam int CMP1_MUX_P_LO    = 0;

    // bits that software can store; the rest read as zero
    localparam logic [7:0] CMP1_MASK_MODE = 8'h33;
    localparam logic [7:0] CMP1_MASK_MUX  = 8'h33;

    // flag indices for the sticky edge flags
    localparam int CMP1_FLAG_RISE = 0;
    localparam int CMP1_FLAG_FALL = 1;
    localparam int CMP1_NFLAGS    = 2;

    // power-up settling time of the analog comparator
    localparam int CMP1_CLK_HZ        = 20_000_000;
    localparam int CMP1_PWRUP_US      = 10;
    localparam int CMP1_PWRUP_CYC     = (CMP1_PWRUP_US * (CMP1_CLK_HZ / 1_000_000) < 1) ? 1 :
                                        CMP1_PWRUP_US * (CMP1_CLK_HZ / 1_000_000);
    localparam int CMP1_CNT_W         = 8;

    // power state, gray coded along off -> warming -> ready
    typedef enum logic [1:0] {
        CMP1_PWR_OFF  = 2'b00,
        CMP1_PWR_WARM = 2'b01,
        CMP1_PWR_RDY  = 2'b11
    } cmp1_pwr_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmp1_bus_req_t;

    // configuration driven to the analog comparator
    typedef struct packed {
        logic       enable;
        logic [1:0] pos_hysteresis_sel;
        logic [1:0] neg_hysteresis_sel;
        logic [1:0] pos_input_sel;
        logic [1:0] neg_input_sel;
        logic [1:0] response_mode_sel;
    } cmp1_cfg_t;

endpackage : cmp1_pkg

/* rtl/cmp1_regs.sv */
/*
 * register bank and edge-event logic of the second analog comparator.
 * assumes a register port master on the same clock with one-cycle strobes,
 * read data expected in the cycle after the read strobe, and an analog
 * comparator whose raw output arrives asynchronously.
 * the settled status only counts cycles after the enable; it cannot see
 * the analog stage, so a slow stage may still be settling when it rises.
 * edge flags are not masked during power-up: software clears them once
 * the stage has settled, which keeps this block free of analog timing.
 */
//
// Behaviour
// [R1] enable bit 7 of control powers the comparator up; 0 keeps it off
// [R2] bit 6 of control reads the live comparator result, read-only
// [R3] bit 5 of control is set by a rising output transition
// [R4] bit 4 of control is set by a falling output transition
// [R5] control bits 3..2 drive positive hysteresis: off, 5, 10, 20 mV
// [R6] control bits 1..0 drive negative hysteresis with the same coding
// [R7] input select bits 5..4 choose the negative input pin
// [R8] input select bits 1..0 choose the positive input pin
// [R9] unused bits of select and mode registers read zero, writes ignored
// [R10] rising events request an interrupt only while mode bit 5 is set
// [R11] falling events request an interrupt only while mode bit 4 is set
// [R12] mode bits 1..0 drive response time, 0 fastest, 3 lowest power
// [R13] software waits about 10 us after enabling before trusting output
// [R14] edge flags stay set until software writes them to zero
// [R15] software clears both flags after enabling or changing mode bits
// [R16] comparator output on a port pin is low while disabled
// [R17] comparator output passes a two-stage synchroniser before edge detect
// [R18] interrupt is flag-and-enable per edge; hardware set beats clear
//
`timescale 1ns/10ps
`default_nettype none

module cmp1_regs (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire cmp1_pkg::cmp1_bus_req_t bus_req,
    output logic [7:0]                   rdata_r,
    input  wire logic                    cmp_raw,
    output cmp1_pkg::cmp1_cfg_t          cfg_r,
    output logic                         pin_out_r,
    output logic                         irq_r,
    output logic                         settled_r
);
    import cmp1_pkg::*;

    // address decode used for both reads and writes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // software-held fields of the three registers
    logic       en_r;
    logic [1:0] hyp_r;
    logic [1:0] hyn_r;
    logic [1:0] nsel_r;
    logic [1:0] psel_r;
    logic       rie_r;
    logic       fie_r;
    logic [1:0] md_r;

    logic       en_nxt;
    logic [1:0] hyp_nxt;
    logic [1:0] hyn_nxt;
    logic [1:0] nsel_nxt;
    logic [1:0] psel_nxt;
    logic       rie_nxt;
    logic       fie_nxt;
    logic [1:0] md_nxt;

    // decoded strobes
    wire        hit_ctrl;
    wire        hit_mode;
    wire        hit_mux;
    wire        wr_ctrl;
    wire        wr_mode;
    wire        wr_mux;

    // comparator output path
    logic       cmp_sync;
    wire        cmp_live;
    logic       cmp_prev_r;
    logic       cmp_prev_nxt;
    wire        rise_evt;
    wire        fall_evt;

    // sticky flags, one per edge direction
    logic [CMP1_NFLAGS-1:0] flag_q;
    wire  [CMP1_NFLAGS-1:0] flag_set;
    wire  [CMP1_NFLAGS-1:0] flag_wval;

    // read path
    wire  [7:0] ctrl_view;
    wire  [7:0] mode_view;
    wire  [7:0] mux_view;
    wire  [7:0] rd_mux;
    logic [7:0] rdata_nxt;

    // interrupt and port pin
    wire        irq_nxt;
    wire        pin_nxt;
    cmp1_cfg_t  cfg_nxt;

    // power-up tracking
    cmp1_pwr_t              pwr_r;
    cmp1_pwr_t              pwr_nxt;
    logic [CMP1_CNT_W-1:0]  cnt_r;
    logic [CMP1_CNT_W-1:0]  cnt_nxt;
    wire                    cnt_done;
    wire                    settled_nxt;

    localparam logic [CMP1_CNT_W-1:0] PWRUP_LAST = CMP1_CNT_W'(CMP1_PWRUP_CYC - 1);

    // configuration port value while reset holds, built from the register
    // reset values so the port and the registers can never disagree
    localparam cmp1_cfg_t CFG_RST = '{
        enable:             CMP1_RST_CTRL[CMP1_CTRL_EN],
        pos_hysteresis_sel: CMP1_RST_CTRL[CMP1_CTRL_HYP_LO +: 2],
        neg_hysteresis_sel: CMP1_RST_CTRL[CMP1_CTRL_HYN_LO +: 2],
        pos_input_sel:      CMP1_RST_MUX[CMP1_MUX_P_LO +: 2],
        neg_input_sel:      CMP1_RST_MUX[CMP1_MUX_N_LO +: 2],
        response_mode_sel:  CMP1_RST_MODE[CMP1_MODE_MD_LO +: 2]
    };

    // register port decode; strobes are never both high at once
    assign hit_ctrl = hit(bus_req.addr, CMP1_OFS_CTRL);
    assign hit_mode = hit(bus_req.addr, CMP1_OFS_MODE);
    assign hit_mux  = hit(bus_req.addr, CMP1_OFS_MUX);
    assign wr_ctrl  = bus_req.wr & hit_ctrl;
    assign wr_mode  = bus_req.wr & hit_mode;
    assign wr_mux   = bus_req.wr & hit_mux;

    // control register write; bit 6 is read-only and not stored
    assign en_nxt   = wr_ctrl ? bus_req.wdata[CMP1_CTRL_EN] : en_r;              // R1
    assign hyp_nxt  = wr_ctrl ? bus_req.wdata[CMP1_CTRL_HYP_LO +: 2] : hyp_r;    // R5
    assign hyn_nxt  = wr_ctrl ? bus_req.wdata[CMP1_CTRL_HYN_LO +: 2] : hyn_r;    // R6

    // input select write; bits 7..6 and 3..2 are dropped
    assign nsel_nxt = wr_mux ? bus_req.wdata[CMP1_MUX_N_LO +: 2] : nsel_r;       // R7
    assign psel_nxt = wr_mux ? bus_req.wdata[CMP1_MUX_P_LO +: 2] : psel_r;       // R8

    // mode write; unused positions are dropped as well
    assign rie_nxt  = wr_mode ? bus_req.wdata[CMP1_MODE_RIE] : rie_r;            // R10
    assign fie_nxt  = wr_mode ? bus_req.wdata[CMP1_MODE_FIE] : fie_r;            // R11
    assign md_nxt   = wr_mode ? bus_req.wdata[CMP1_MODE_MD_LO +: 2] : md_r;      // R12

    // configuration registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_r   <= CMP1_RST_CTRL[CMP1_CTRL_EN];
            hyp_r  <= CMP1_RST_CTRL[CMP1_CTRL_HYP_LO +: 2];
            hyn_r  <= CMP1_RST_CTRL[CMP1_CTRL_HYN_LO +: 2];
            nsel_r <= CMP1_RST_MUX[CMP1_MUX_N_LO +: 2];
            psel_r <= CMP1_RST_MUX[CMP1_MUX_P_LO +: 2];
            rie_r  <= CMP1_RST_MODE[CMP1_MODE_RIE];
            fie_r  <= CMP1_RST_MODE[CMP1_MODE_FIE];
            md_r   <= CMP1_RST_MODE[CMP1_MODE_MD_LO +: 2];
        end else begin
            en_r   <= en_nxt;
            hyp_r  <= hyp_nxt;
            hyn_r  <= hyn_nxt;
            nsel_r <= nsel_nxt;
            psel_r <= psel_nxt;
            rie_r  <= rie_nxt;
            fie_r  <= fie_nxt;
            md_r   <= md_nxt;
        end
    end

    // configuration out to the analog side, registered copy of the fields
    // codes pass through undecoded; the analog stage owns their meaning
    always_comb begin
        cfg_nxt                    = '0;
        cfg_nxt.enable             = en_nxt;    // R1
        cfg_nxt.pos_hysteresis_sel = hyp_nxt;   // R5
        cfg_nxt.neg_hysteresis_sel = hyn_nxt;   // R6
        cfg_nxt.pos_input_sel      = psel_nxt;  // R8
        cfg_nxt.neg_input_sel      = nsel_nxt;  // R7
        cfg_nxt.response_mode_sel  = md_nxt;    // R12
    end

    // driven from the next values so cfg_r equals the register bits exactly
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_r <= CFG_RST;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // raw output is asynchronous to clk, so it is synchronised first
    // the pin copy uses the synchronised value as well, so it lags the raw
    // output by three edges; an unsynchronised pin route is not offered
    cmp1_sync u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (cmp_raw),
        .sync_out (cmp_sync)
    ); // R17

    // a powered-down comparator reads low and drives its pin low
    assign cmp_live     = en_r & cmp_sync;     // R2
    assign cmp_prev_nxt = cmp_live;

    // previous sample for edge detection; never reads the first stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmp_prev_r <= 1'b0;
        end else begin
            cmp_prev_r <= cmp_prev_nxt;
        end
    end

    // edges compare successive synchronised samples; turning the
    // comparator off is not an output transition, so only count while on
    assign rise_evt = en_r &  cmp_live & ~cmp_prev_r;  // R3 R17
    assign fall_evt = en_r & ~cmp_live &  cmp_prev_r;  // R4 R17

    // per-flag set and write value, indexed by the flag position
    assign flag_set[CMP1_FLAG_RISE]  = rise_evt;
    assign flag_set[CMP1_FLAG_FALL]  = fall_evt;
    assign flag_wval[CMP1_FLAG_RISE] = bus_req.wdata[CMP1_CTRL_RISE];
    assign flag_wval[CMP1_FLAG_FALL] = bus_req.wdata[CMP1_CTRL_FALL];

    // sticky flags; only a software write can lower them
    // the write value comes straight from the data bus, so writing 1 sets
    // a flag by software, which lets a handler force the request
    generate
        for (genvar i = 0; i < CMP1_NFLAGS; i++) begin : g_flag
            cmp1_flag u_flag (
                .clk    (clk),
                .rst_b  (rst_b),
                .set    (flag_set[i]),
                .wr_en  (wr_ctrl),
                .wr_val (flag_wval[i]),
                .flag_r (flag_q[i])
            ); // R3 R4 R14 R18
        end
    endgenerate

    // interrupt request, one cycle behind the flags it reflects
    // it is a level with no pending bit of its own: it stays up until
    // software clears the flag or the matching enable
    assign irq_nxt = (flag_q[CMP1_FLAG_RISE] & rie_r)   // R10 R18
                   | (flag_q[CMP1_FLAG_FALL] & fie_r);  // R11 R18

    // port pin copy of the result; low whenever the comparator is off
    assign pin_nxt = en_r & cmp_live; // R16

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_r     <= 1'b0;
            pin_out_r <= 1'b0;
        end else begin
            irq_r     <= irq_nxt;
            pin_out_r <= pin_nxt;
        end
    end

    // register views as software reads them
    // reads have no side effect: flags drop only on an explicit write,
    // so a polling loop cannot lose an edge
    assign ctrl_view = {en_r, cmp_live, flag_q[CMP1_FLAG_RISE],
                        flag_q[CMP1_FLAG_FALL], hyp_r, hyn_r};      // R2
    assign mode_view = {2'b00, rie_r, fie_r, 2'b00, md_r} & CMP1_MASK_MODE;  // R9
    assign mux_view  = {2'b00, nsel_r, 2'b00, psel_r} & CMP1_MASK_MUX;       // R9

    // unmapped addresses read as zero
    assign rd_mux = hit_ctrl ? ctrl_view :
                    hit_mode ? mode_view :
                    hit_mux  ? mux_view  : 8'h00;

    // read data stands only in the cycle after the strobe, zero otherwise
    assign rdata_nxt = bus_req.rd ? rd_mux : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // power-up tracker: a status hint only, it never masks flags, since
    // software owns the settling wait and the flag clean-up after it
    // settled rises CMP1_PWRUP_CYC + 1 edges after the enabling write:
    // one edge to leave the off state, then the full count while warming
    assign cnt_done = (cnt_r == PWRUP_LAST);

    always_comb begin
        pwr_nxt = pwr_r;
        cnt_nxt = cnt_r;
        case (pwr_r)
            // off: counter parked at zero until the enable appears
            CMP1_PWR_OFF: begin
                cnt_nxt = '0;
                if (en_r) begin
                    pwr_nxt = CMP1_PWR_WARM;
                end
            end
            // warming: a disable in mid-count drops straight back to off
            CMP1_PWR_WARM: begin
                cnt_nxt = cnt_r + CMP1_CNT_W'(1);
                if (!en_r) begin
                    pwr_nxt = CMP1_PWR_OFF;
                    cnt_nxt = '0;
                end else if (cnt_done) begin
                    pwr_nxt = CMP1_PWR_RDY;
                    cnt_nxt = '0;
                end
            end
            // ready: holds until software clears the enable
            CMP1_PWR_RDY: begin
                cnt_nxt = '0;
                if (!en_r) begin
                    pwr_nxt = CMP1_PWR_OFF;
                end
            end
            default: begin
                pwr_nxt = CMP1_PWR_OFF;
                cnt_nxt = '0;
            end
        endcase
    end

    // settled goes high with the ready state and drops one edge after the enable clears
    assign settled_nxt = (pwr_nxt == CMP1_PWR_RDY); // R13

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr_r     <= CMP1_PWR_OFF;
            cnt_r     <= '0;
            settled_r <= 1'b0;
        end else begin
            pwr_r     <= pwr_nxt;
            cnt_r     <= cnt_nxt;
            settled_r <= settled_nxt;
        end
    end

endmodule : cmp1_regs

`default_nettype wire

/* rtl/cmp1_sync.sv */
/*
 * two-stage synchroniser for the asynchronous comparator output.
 * assumes a single system clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp1_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      sync_out
);
    import cmp1_pkg::*;

    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : cmp1_sync

`default_nettype wire

/* tb/cmp1_analog_model.sv */
/* behavioural analog comparator on the far side of the register bank.
   assumes level tells which input is higher; it is driven by the bench. */
`timescale 1ns/10ps
`default_nettype none
module cmp1_analog_model (
    input  wire logic                clk,
    input  wire cmp1_pkg::cmp1_cfg_t cfg,
    input  wire logic                level,
    output logic                     cmp_raw
);
    import cmp1_pkg::*;
    logic lvl_d;

    initial cmp_raw = 1'b0;

    // slow modes answer a cycle late; a powered-down stage wanders every cycle
    always @(posedge clk) begin
        lvl_d <= level;
        if (!cfg.enable) begin
            cmp_raw <= ~cmp_raw;
        end else if (cfg.response_mode_sel == 2'b00) begin
            cmp_raw <= level;
        end else begin
            cmp_raw <= lvl_d;
        end
    end
endmodule : cmp1_analog_model
`default_nettype wire

/* tb/cmp1_regs_assertions.sv */
/* concurrent checks on the comparator register bank ports.
   assumes one clock, synchronous active-low reset, attached by bind. */
`timescale 1ns/10ps
`default_nettype none
module cmp1_regs_chk (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire cmp1_pkg::cmp1_bus_req_t bus_req,
    input wire logic [7:0]              rdata_r,
    input wire logic                    cmp_raw,
    input wire cmp1_pkg::cmp1_cfg_t     cfg_r,
    input wire logic                    pin_out_r,
    input wire logic                    irq_r,
    input wire logic                    settled_r
);
    import cmp1_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // write decodes
    wire wr_ctrl = bus_req.wr && bus_req.addr == CMP1_OFS_CTRL;
    wire wr_mode = bus_req.wr && bus_req.addr == CMP1_OFS_MODE;
    wire wr_mux  = bus_req.wr && bus_req.addr == CMP1_OFS_MUX;
    logic rie_r;
    logic fie_r;

    // shadow of the interrupt enables, since mode bits 5 and 4 reach a port only on rdata_r after a mode read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rie_r <= 1'b0;
            fie_r <= 1'b0;
        end else if (wr_mode) begin
            rie_r <= bus_req.wdata[5];
            fie_r <= bus_req.wdata[4];
        end
    end

    property p_en; wr_ctrl |=> cfg_r.enable == $past(bus_req.wdata[7]); endproperty
    property p_hyp; wr_ctrl |=> cfg_r.pos_hysteresis_sel == $past(bus_req.wdata[3:2]); endproperty
    property p_hyn; wr_ctrl |=> cfg_r.neg_hysteresis_sel == $past(bus_req.wdata[1:0]); endproperty
    property p_nsel; wr_mux |=> cfg_r.neg_input_sel == $past(bus_req.wdata[5:4]); endproperty
    property p_psel; wr_mux |=> cfg_r.pos_input_sel == $past(bus_req.wdata[1:0]); endproperty
    property p_md; wr_mode |=> cfg_r.response_mode_sel == $past(bus_req.wdata[1:0]); endproperty
    property p_unused; bus_req.rd && bus_req.addr != CMP1_OFS_CTRL |=> (rdata_r & 8'hCC) == 8'h00; endproperty
    property p_pin_off; !cfg_r.enable |=> !pin_out_r; endproperty
    property p_sync; (cfg_r.enable && cmp_raw) [*4] |=> pin_out_r; endproperty
    property p_irq_off; !rie_r && !fie_r |=> !irq_r; endproperty
    property p_rise_irq; rie_r && $rose(pin_out_r) |=> irq_r; endproperty
    property p_fall_irq; fie_r && $past(cfg_r.enable) && $fell(pin_out_r) |=> irq_r; endproperty
    property p_settle; !cfg_r.enable |=> !settled_r; endproperty

    a_en: assert property (p_en) else $error("enable not taken from write");
    a_hyp: assert property (p_hyp) else $error("positive hysteresis wrong");
    a_hyn: assert property (p_hyn) else $error("negative hysteresis wrong");
    a_nsel: assert property (p_nsel) else $error("negative input select wrong");
    a_psel: assert property (p_psel) else $error("positive input select wrong");
    a_md: assert property (p_md) else $error("response mode wrong");
    a_unused: assert property (p_unused) else $error("unused bits read nonzero");
    a_pin_off: assert property (p_pin_off) else $error("pin high while disabled");
    a_sync: assert property (p_sync) else $error("result not through synchroniser");
    a_irq_off: assert property (p_irq_off) else $error("irq with both enables off");
    a_rise_irq: assert property (p_rise_irq) else $error("rising edge gave no irq");
    a_fall_irq: assert property (p_fall_irq) else $error("falling edge gave no irq");
    a_settle: assert property (p_settle) else $error("settled while disabled");

    c_irq: cover property ($rose(irq_r));
    c_pin: cover property ($rose(pin_out_r));
    c_settled: cover property ($rose(settled_r));
endmodule : cmp1_regs_chk

bind cmp1_regs cmp1_regs_chk chk (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata_r(rdata_r),
    .cmp_raw(cmp_raw), .cfg_r(cfg_r), .pin_out_r(pin_out_r), .irq_r(irq_r), .settled_r(settled_r));
`default_nettype wire

/* tb/tb.sv */
/* self-checking bench for the comparator register bank.
   assumes the analog model on cmp_raw and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cmp1_pkg::*;
    logic          clk;
    logic          rst_b;
    logic          level;
    logic          cmp_raw;
    cmp1_bus_req_t req;
    logic [7:0]    rdata_r;
    cmp1_cfg_t     cfg_r;
    logic          pin_out_r;
    logic          irq_r;
    logic          settled_r;
    int            n_fail;
    int            n_compared;
    int            seed;
    int            cyc = 0;
    logic [7:0]    d;
    logic [7:0]    v;

    cmp1_regs uut (.clk(clk), .rst_b(rst_b), .bus_req(req), .rdata_r(rdata_r), .cmp_raw(cmp_raw),
                   .cfg_r(cfg_r), .pin_out_r(pin_out_r), .irq_r(irq_r), .settled_r(settled_r));
    cmp1_analog_model model (.clk(clk), .cfg(cfg_r), .level(level), .cmp_raw(cmp_raw));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard; the tests need well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk);
        req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // read data is taken in the single cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 v = rdata_r;
        check(name, v, exp);
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // control reads back with the enable off: live result reads 0, bit 6 is read-only
    function automatic logic [7:0] ctrl_off(input logic [7:0] w);
        return w & 8'h3F;
    endfunction : ctrl_off

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        req = '0;
        level = 1'b0;
        rst_b = 1'b0;
        n_fail = 0;
        n_compared = 0;
        seed = 49;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rchk(CMP1_OFS_CTRL, 8'h00, "control reset");
        rchk(CMP1_OFS_MODE, 8'h02, "mode reset");
        rchk(CMP1_OFS_MUX, 8'h00, "select reset");
        wr(8'h9B, 8'hFF);
        rchk(8'h9B, 8'h00, "unmapped read");
        $display("reset test done");
        // random configuration, seen through the port and the cfg outputs
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            wr(CMP1_OFS_MUX, d);
            rchk(CMP1_OFS_MUX, d & 8'h33, "select");
            check("neg sel", 8'(cfg_r.neg_input_sel), 8'(d[5:4]));
            check("pos sel", 8'(cfg_r.pos_input_sel), 8'(d[1:0]));
            wr(CMP1_OFS_MODE, d ^ 8'hA5);
            rchk(CMP1_OFS_MODE, (d ^ 8'hA5) & 8'h33, "mode");
            check("resp mode", 8'(cfg_r.response_mode_sel), 8'(d[1:0] ^ 2'b01));
            wr(CMP1_OFS_CTRL, d & 8'h7F);
            rchk(CMP1_OFS_CTRL, ctrl_off(d), "control");
            check("pos hyst", 8'(cfg_r.pos_hysteresis_sel), 8'(d[3:2]));
            check("neg hyst", 8'(cfg_r.neg_hysteresis_sel), 8'(d[1:0]));
        end
        wr(CMP1_OFS_CTRL, 8'h00);
        $display("random register test done");
        // slow response mode, both edge interrupts on
        wr(CMP1_OFS_MODE, 8'h33);
        wr(CMP1_OFS_CTRL, 8'h80);
        idle(8);
        wr(CMP1_OFS_CTRL, 8'h80);
        rchk(CMP1_OFS_CTRL, 8'h80, "enabled quiet");
        @(posedge clk);
        level <= 1'b1;
        idle(8);
        rchk(CMP1_OFS_CTRL, 8'hE0, "rise");
        check("irq rise", 8'(irq_r), 8'h01);
        check("pin high", 8'(pin_out_r), 8'h01);
        idle(20);
        rchk(CMP1_OFS_CTRL, 8'hE0, "rise sticky");
        wr(CMP1_OFS_CTRL, 8'h80);
        idle(2);
        rchk(CMP1_OFS_CTRL, 8'hC0, "rise cleared");
        check("irq cleared", 8'(irq_r), 8'h00);
        @(posedge clk);
        level <= 1'b0;
        idle(8);
        rchk(CMP1_OFS_CTRL, 8'h90, "fall");
        check("irq fall", 8'(irq_r), 8'h01);
        wr(CMP1_OFS_MODE, 8'h03);
        idle(2);
        check("irq masked", 8'(irq_r), 8'h00);
        wr(CMP1_OFS_CTRL, 8'h10);
        idle(8);
        rchk(CMP1_OFS_CTRL, 8'h10, "disabled");
        check("pin off", 8'(pin_out_r), 8'h00);
        $display("edge test done");
        // power-up settling count
        wr(CMP1_OFS_CTRL, 8'h80);
        idle(CMP1_PWRUP_CYC);
        #1 check("settling", 8'(settled_r), 8'h00);
        @(posedge clk);
        #1 check("settled", 8'(settled_r), 8'h01);
        wr(CMP1_OFS_CTRL, 8'h00);
        idle(2);
        check("unsettled", 8'(settled_r), 8'h00);
        // fast mode, clearing write lands on the very edge the rise flag sets
        wr(CMP1_OFS_MODE, 8'h00);
        wr(CMP1_OFS_CTRL, 8'h80);
        idle(8);
        @(posedge clk);
        level <= 1'b1;
        idle(2);
        wr(CMP1_OFS_CTRL, 8'h80);
        rchk(CMP1_OFS_CTRL, 8'hE0, "set beats clear");
        $display("settling test done");
        // reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        idle(3);
        rst_b <= 1'b1;
        rchk(CMP1_OFS_MODE, 8'h02, "mode after reset");
        $display("second reset test done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
